// *** logic/dhi_regs.svh ***
// Constants of the display host link: select codes, bit positions, timing
// Function
// - Data select high: memory; low: command
// - Enable style: select high reads, low writes
// - Enable style: transfer needs enable high, select low
// - Strobe style: write low with chip select low
// - Eight-bit two-way bus toward the host
// - Serial: clock on bit 0, data bit 1
// - Parallel both styles, serial and I2C links
// - Two static inputs choose the active link
// - Reset pin low restores all interface state
`ifndef DHI_REGS_SVH
`define DHI_REGS_SVH

// Link select codes, {link_select_1, link_select_0}
`define LINK_SEL_ESTROBE  2'h2
`define LINK_SEL_RWSTROBE 2'h3
`define LINK_SEL_I2C      2'h1
`define LINK_SEL_SERIAL   2'h0

// Bit positions on the byte bus and in the I2C control byte
`define SER_CLK_BIT  0
`define SER_DATA_BIT 1
`define I2C_CO_BIT   7
`define I2C_DC_BIT   6

// Bus output-enable levels: released, driven, I2C acknowledge
`define BUS_RELEASED 8'hFF
`define BUS_DRIVEN   8'h00
`define I2C_ACK_OE_N 8'hFD

// Timing of the host end
`define CORE_CLK_NS    50
`define TICK_NS        100
`define TICK_CYC       ((`TICK_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define ACTIVE_TICKS   4
`define RES_HOLD_NS    3000
`define RES_HOLD_TICKS (`RES_HOLD_NS / `TICK_NS)

`endif

// *** logic/dhi_pkg.sv ***
// Types shared by both ends of the display host link
`include "dhi_regs.svh"
package dhi_pkg;

  // Active host link
  typedef enum {LINK_ESTROBE, LINK_RWSTROBE, LINK_I2C, LINK_SERIAL} link_mode_e;

  // Decode of the two static select inputs
  function automatic link_mode_e sel_to_mode(logic [1:0] sel);
    case (sel)
      `LINK_SEL_ESTROBE:  return LINK_ESTROBE;
      `LINK_SEL_RWSTROBE: return LINK_RWSTROBE;
      `LINK_SEL_I2C:      return LINK_I2C;
      default:            return LINK_SERIAL;
    endcase
  endfunction

endpackage

// *** logic/host_link_if.sv ***
// Pins between host and display, with the wired bus level
interface host_link_if;
  logic       res_n;
  logic       link_select_0;
  logic       link_select_1;
  logic       cs_n;
  logic       data_command_select;
  logic       write_strobe_n;
  logic       enable_read;
  logic [7:0] host_drive;
  logic [7:0] host_oe_n;
  logic [7:0] dev_drive;
  logic [7:0] dev_oe_n;
  logic [7:0] host_byte_bus;

  // Pulled-up bus: a driver pulling a bit low wins
  assign host_byte_bus = (host_drive | host_oe_n) & (dev_drive | dev_oe_n);

  modport host (
    output res_n, link_select_0, link_select_1, cs_n,
    output data_command_select, write_strobe_n, enable_read,
    output host_drive, host_oe_n,
    input  host_byte_bus
  );

  modport device (
    input  res_n, link_select_0, link_select_1, cs_n,
    input  data_command_select, write_strobe_n, enable_read,
    input  host_byte_bus,
    output dev_drive, dev_oe_n
  );
endinterface // host_link_if

// *** logic/display_port_end.sv ***
// Display end of the host link: pin sampling, link decode, byte routing
`include "dhi_regs.svh"
module display_port_end
  import dhi_pkg::*;
#(
  parameter logic [6:0] I2C_ADDR = 7'h3C
) (
  // Host pins
  host_link_if.device link,
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RST_N,
  // Byte offered to the host on a read
  input  wire logic [7:0] RD_DATA,
  // Received bytes
  output logic [7:0]      BYTE,
  output logic            MEM_WE,
  output logic            CMD_WE,
  // Read handshake
  output logic            READ_DONE,
  output logic            READ_IS_DATA,
  // Status
  output logic            IN_RESET
);

  // Reserved I2C addresses cannot be served
  if (I2C_ADDR[6:3] == 4'h0 || I2C_ADDR[6:3] == 4'hF) begin : g_bad_addr
    $error("I2C_ADDR lies in a reserved address range");
  end

  typedef enum {I_IDLE, I_ADDR, I_CTRL, I_DATA} i2c_state_e;

  // Pin vector: res, sel1, sel0, cs_n, dc, wr, rd, bus
  logic [14:0] pin_s1;
  logic [14:0] pin_s2;
  logic [14:0] pin_s3;
  logic        rst_all;
  link_mode_e  mode;
  logic        cs_n_s;
  logic [1:0]  ph_now;
  logic [1:0]  ph_p;
  logic        par_take;
  logic        rd_start;
  logic        rd_end;
  logic [2:0]  ser_cnt;
  logic [6:0]  ser_sh;
  logic        ser_on;
  logic        ser_rise;
  logic        ser_take;
  i2c_state_e  i_st;
  logic [3:0]  i_cnt;
  logic [7:0]  i_sh;
  logic        i_ack;
  logic        i_co;
  logic        i_dc;
  logic        i_on;
  logic        i_start;
  logic        i_stop;
  logic        i_rise;
  logic        i_fall;
  logic        i_match;
  logic        i_take;
  logic        got;
  logic [7:0]  got_byte;
  logic        got_dc;

  // Write and read phases of the two parallel styles, {write, read}
  function automatic logic [1:0] strobe_phase(link_mode_e m,
                                              logic [2:0] p);
    logic wph;
    logic rph;
    wph = 1'b0;
    rph = 1'b0;
    if (m == LINK_ESTROBE) begin
      wph = !p[2] && p[0] && !p[1];
      rph = !p[2] && p[0] && p[1];
    end else if (m == LINK_RWSTROBE) begin
      wph = !p[2] && !p[1];
      rph = !p[2] && !p[0] && p[1];
    end
    return {wph, rph};
  endfunction

  // Two-stage synchroniser plus one history stage for edges
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pin_s1 <= 15'h3FFF; // Reset pin bit starts low: no early exit
      pin_s2 <= 15'h3FFF;
      pin_s3 <= 15'h3FFF;
    end else begin
      pin_s1 <= {link.res_n, link.link_select_1, link.link_select_0,
                 link.cs_n, link.data_command_select,
                 link.write_strobe_n, link.enable_read,
                 link.host_byte_bus};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Reset pin and mode decode
  assign rst_all = !RST_N || !pin_s2[14];
  assign mode    = sel_to_mode(pin_s2[13:12]);
  assign cs_n_s  = pin_s2[11];

  // Parallel styles: phases now and one cycle before
  assign ph_now   = strobe_phase(mode, {pin_s2[11], pin_s2[9], pin_s2[8]});
  assign ph_p     = strobe_phase(mode, {pin_s3[11], pin_s3[9], pin_s3[8]});
  assign par_take = ph_p[1] && !ph_now[1];
  assign rd_start = ph_now[0] && !ph_p[0];
  assign rd_end   = ph_p[0] && !ph_now[0];

  // Serial: clock on one bus bit, data on another
  assign ser_on   = mode == LINK_SERIAL && !cs_n_s;
  assign ser_rise = ser_on && pin_s2[`SER_CLK_BIT]
                    && !pin_s3[`SER_CLK_BIT];
  assign ser_take = ser_rise && ser_cnt == 3'h7;

  // Serial shifter, MSB first; chip select high restarts the byte
  always_ff @(posedge CORE_CLK) begin
    if (rst_all || !ser_on) begin
      ser_cnt <= 3'h0;
      ser_sh  <= 7'h00;
    end else if (ser_rise) begin
      ser_sh  <= {ser_sh[5:0], pin_s3[`SER_DATA_BIT]};
      ser_cnt <= ser_cnt + 3'h1;
    end
  end

  // I2C: clock on the serial clock bit, data on the serial data bit
  assign i_on    = mode == LINK_I2C && !cs_n_s;
  assign i_start = i_on && pin_s2[`SER_CLK_BIT] && pin_s3[`SER_CLK_BIT]
                   && pin_s3[`SER_DATA_BIT] && !pin_s2[`SER_DATA_BIT];
  assign i_stop  = i_on && pin_s2[`SER_CLK_BIT] && pin_s3[`SER_CLK_BIT]
                   && !pin_s3[`SER_DATA_BIT] && pin_s2[`SER_DATA_BIT];
  assign i_rise  = i_on && pin_s2[`SER_CLK_BIT] && !pin_s3[`SER_CLK_BIT];
  assign i_fall  = i_on && !pin_s2[`SER_CLK_BIT] && pin_s3[`SER_CLK_BIT];
  assign i_match = i_sh[7:1] == I2C_ADDR && !i_sh[0];
  assign i_take  = i_fall && i_cnt == 4'h8 && i_st == I_DATA;

  // I2C write receiver: address, control byte, then data bytes
  always_ff @(posedge CORE_CLK) begin
    if (rst_all || !i_on || i_stop) begin
      i_st  <= I_IDLE;
      i_cnt <= 4'h0;
      i_ack <= 1'b0;
      i_co  <= 1'b0;
      i_dc  <= 1'b0;
      i_sh  <= 8'h00;
    end else if (i_start) begin
      i_st  <= I_ADDR;
      i_cnt <= 4'h0;
      i_ack <= 1'b0;
    end else if (i_rise && i_cnt < 4'h8) begin
      i_sh  <= {i_sh[6:0], pin_s2[`SER_DATA_BIT]};
      i_cnt <= i_cnt + 4'h1;
    end else if (i_fall && i_cnt == 4'h8) begin
      i_cnt <= 4'h9;
      case (i_st)
        I_ADDR: begin
          i_ack <= i_match;
          i_st  <= i_match ? I_CTRL : I_IDLE;
        end
        I_CTRL: begin
          i_ack <= 1'b1;
          i_co  <= i_sh[`I2C_CO_BIT];
          i_dc  <= i_sh[`I2C_DC_BIT];
          i_st  <= I_DATA;
        end
        I_DATA: begin
          i_ack <= 1'b1;
          i_st  <= i_co ? I_CTRL : I_DATA;
        end
        default: begin
          i_ack <= 1'b0;
        end
      endcase
    end else if (i_fall && i_cnt == 4'h9) begin
      i_cnt <= 4'h0;
      i_ack <= 1'b0;
    end
  end

  // Pick the byte of the active link
  always_comb begin
    got      = 1'b0;
    got_byte = 8'h00;
    got_dc   = 1'b0;
    if (par_take) begin
      got      = 1'b1;
      got_byte = pin_s3[7:0];
      got_dc   = pin_s3[10];
    end else if (ser_take) begin
      got      = 1'b1;
      got_byte = {ser_sh, pin_s3[`SER_DATA_BIT]};
      got_dc   = pin_s2[10];
    end else if (i_take) begin
      got      = 1'b1;
      got_byte = i_sh;
      got_dc   = i_dc;
    end
  end

  // Route each byte to display memory or the command register
  always_ff @(posedge CORE_CLK) begin
    if (rst_all) begin
      BYTE   <= 8'h00;
      MEM_WE <= 1'b0;
      CMD_WE <= 1'b0;
    end else begin
      MEM_WE <= got && got_dc;
      CMD_WE <= got && !got_dc;
      if (got) begin
        BYTE <= got_byte;
      end
    end
  end

  // Bus drive: read data during a read phase, I2C acknowledge, else off
  always_ff @(posedge CORE_CLK) begin
    if (rst_all) begin
      link.dev_drive <= 8'h00;
      link.dev_oe_n  <= `BUS_RELEASED;
      READ_DONE      <= 1'b0;
      READ_IS_DATA   <= 1'b0;
    end else begin
      READ_DONE <= rd_end;
      if (rd_start) begin
        link.dev_drive <= RD_DATA;
        READ_IS_DATA   <= pin_s2[10];
      end else if (mode == LINK_I2C) begin
        link.dev_drive <= 8'h00;
      end
      if (ph_now[0]) begin
        link.dev_oe_n <= `BUS_DRIVEN;
      end else if (mode == LINK_I2C && i_ack) begin
        link.dev_oe_n <= `I2C_ACK_OE_N;
      end else begin
        link.dev_oe_n <= `BUS_RELEASED;
      end
    end
  end

  // Reset status
  always_ff @(posedge CORE_CLK) begin
    IN_RESET <= rst_all;
  end

endmodule // display_port_end

// *** logic/host_port_end.sv ***
// Host end of the display link: parallel and serial byte transfers
`include "dhi_regs.svh"
module host_port_end
  import dhi_pkg::*;
#(
  parameter int unsigned TICK_CYC     = `TICK_CYC,
  parameter int unsigned ACTIVE_TICKS = `ACTIVE_TICKS
) (
  // Display pins
  host_link_if.host  link,
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RST_N,
  // Static link choice
  input  wire logic [1:0] LINK_MODE,
  // Requests
  input  wire logic       REQ_VALID,
  input  wire logic       REQ_READ,
  input  wire logic       REQ_IS_DATA,
  input  wire logic [7:0] REQ_DATA,
  output logic            REQ_READY,
  // Read answers
  output logic            RSP_VALID,
  output logic [7:0]      RSP_DATA
);

  // The display needs several cycles to see and answer a strobe
  if (TICK_CYC < 2 || TICK_CYC > 16 || ACTIVE_TICKS < 4
      || ACTIVE_TICKS > 255) begin : g_bad_timing
    $error("TICK_CYC or ACTIVE_TICKS out of range");
  end

  typedef enum {H_RESET, H_IDLE, H_SETUP, H_ACTIVE, H_RECOVER,
                H_SER_LOW, H_SER_HIGH} host_state_e;

  host_state_e st;
  link_mode_e  mode;
  logic [3:0]  tick_cnt;
  logic        tick;
  logic [7:0]  ph_cnt;
  logic [7:0]  bus_s1;
  logic [7:0]  bus_s2;
  logic        is_read;
  logic [2:0]  bit_idx;
  logic [7:0]  data;

  // Serial pins: data bit and clock bit on the bus
  function automatic logic [7:0] ser_pins(logic d, logic c);
    logic [7:0] v;
    v = 8'h00;
    v[`SER_DATA_BIT] = d;
    v[`SER_CLK_BIT]  = c;
    return v;
  endfunction

  assign mode = sel_to_mode(LINK_MODE);

  // Phase tick divider, held in idle so phases start aligned
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || st == H_IDLE) begin
      tick_cnt <= 4'h0;
      tick     <= 1'b0;
    end else if (tick_cnt == 4'(TICK_CYC - 1)) begin
      tick_cnt <= 4'h0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 4'h1;
      tick     <= 1'b0;
    end
  end

  // Bus synchroniser for read data
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      bus_s1 <= `BUS_RELEASED;
      bus_s2 <= `BUS_RELEASED;
    end else begin
      bus_s1 <= link.host_byte_bus;
      bus_s2 <= bus_s1;
    end
  end

  // Static select pins
  always_ff @(posedge CORE_CLK) begin
    link.link_select_1 <= LINK_MODE[1];
    link.link_select_0 <= LINK_MODE[0];
  end

  // Transfer sequencer
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      st                       <= H_RESET;
      ph_cnt                   <= 8'(`RES_HOLD_TICKS - 1);
      REQ_READY                <= 1'b0;
      RSP_VALID                <= 1'b0;
      RSP_DATA                 <= 8'h00;
      link.res_n               <= 1'b0;
      link.cs_n                <= 1'b1;
      link.data_command_select <= 1'b0;
      link.write_strobe_n      <= 1'b1;
      link.enable_read         <= 1'b0;
      link.host_drive          <= 8'h00;
      link.host_oe_n           <= `BUS_RELEASED;
      is_read                  <= 1'b0;
      bit_idx                  <= 3'h0;
      data                     <= 8'h00;
    end else begin
      RSP_VALID <= 1'b0;
      case (st)
        H_RESET: begin
          if (tick) begin
            if (ph_cnt == 8'h00) begin
              link.res_n <= 1'b1;
              st         <= H_IDLE;
            end else begin
              ph_cnt <= ph_cnt - 8'h01;
            end
          end
        end
        H_IDLE: begin
          link.enable_read <= mode != LINK_ESTROBE;
          REQ_READY        <= mode != LINK_I2C;
          if (REQ_VALID && REQ_READY) begin
            REQ_READY                <= 1'b0;
            link.cs_n                <= 1'b0;
            link.data_command_select <= REQ_IS_DATA;
            is_read  <= REQ_READ && mode != LINK_SERIAL;
            data     <= REQ_DATA;
            link.write_strobe_n <= mode == LINK_ESTROBE ? REQ_READ
                                                        : 1'b1;
            link.host_oe_n <= (REQ_READ && mode != LINK_SERIAL)
                              ? `BUS_RELEASED : `BUS_DRIVEN;
            if (mode == LINK_SERIAL) begin
              link.host_drive <= ser_pins(REQ_DATA[7], 1'b0);
              bit_idx         <= 3'h7;
              st              <= H_SER_LOW;
            end else begin
              link.host_drive <= REQ_DATA;
              st              <= H_SETUP;
            end
          end
        end
        H_SETUP: begin
          if (tick) begin
            if (mode == LINK_ESTROBE) begin
              link.enable_read <= 1'b1;
            end else if (is_read) begin
              link.enable_read <= 1'b0;
            end else begin
              link.write_strobe_n <= 1'b0;
            end
            ph_cnt <= 8'(ACTIVE_TICKS - 1);
            st     <= H_ACTIVE;
          end
        end
        H_ACTIVE: begin
          if (tick) begin
            if (ph_cnt == 8'h00) begin
              link.enable_read <= mode != LINK_ESTROBE;
              if (mode != LINK_ESTROBE) begin
                link.write_strobe_n <= 1'b1;
              end
              if (is_read) begin
                RSP_VALID <= 1'b1;
                RSP_DATA  <= bus_s2;
              end
              st <= H_RECOVER;
            end else begin
              ph_cnt <= ph_cnt - 8'h01;
            end
          end
        end
        H_RECOVER: begin
          if (tick) begin
            link.cs_n           <= 1'b1;
            link.host_oe_n      <= `BUS_RELEASED;
            link.write_strobe_n <= 1'b1;
            st                  <= H_IDLE;
          end
        end
        H_SER_LOW: begin
          if (tick) begin
            link.host_drive <= ser_pins(data[bit_idx], 1'b1);
            st              <= H_SER_HIGH;
          end
        end
        H_SER_HIGH: begin
          if (tick) begin
            if (bit_idx == 3'h0) begin
              st <= H_RECOVER;
            end else begin
              link.host_drive <= ser_pins(data[bit_idx - 3'h1], 1'b0);
              bit_idx         <= bit_idx - 3'h1;
              st              <= H_SER_LOW;
            end
          end
        end
        default: begin
          st <= H_IDLE;
        end
      endcase
    end
  end

endmodule // host_port_end

// *** tb/host_link_props.sv ***
// Concurrent checks on the pins between the host end and the display end
`include "dhi_regs.svh"
module host_link_props (
  // Clock and reset
  input wire logic       CORE_CLK,
  input wire logic       RST_N,
  // Host side pins
  input wire logic       res_n,
  input wire logic       link_select_0,
  input wire logic       link_select_1,
  input wire logic       cs_n,
  input wire logic       data_command_select,
  input wire logic       write_strobe_n,
  input wire logic       enable_read,
  input wire logic [7:0] host_oe_n,
  // Display side pins
  input wire logic [7:0] dev_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] sel;

  // Active link code as seen on the select pins
  assign sel = {link_select_1, link_select_0};

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  // Pins idle and display reset held right after core reset
  a_reset_idle_pins: assert property ($rose(RST_N) |-> !res_n && cs_n
    && &host_oe_n && &dev_oe_n) else $error("pins not idle after reset");
  a_res_hold_low: assert property ($rose(RST_N) |-> (!res_n) [*8])
    else $error("display reset released too early");
  a_res_pin_quiet: assert property ((!res_n) [*4] |-> &dev_oe_n)
    else $error("display drives bus while its reset pin is low");
  a_cs_gates_bus: assert property (cs_n [*4] |-> &dev_oe_n)
    else $error("display drives bus while not selected");
  // Bus direction follows the transfer kind
  a_write_bus_free: assert property ((sel == `LINK_SEL_RWSTROBE
    && !write_strobe_n) || (sel == `LINK_SEL_ESTROBE && enable_read
    && !write_strobe_n) |-> &dev_oe_n)
    else $error("display drives bus during a write");
  a_strobe_read_drive: assert property ((sel == `LINK_SEL_RWSTROBE
    && !cs_n && !enable_read) [*6] |-> dev_oe_n == `BUS_DRIVEN)
    else $error("display not driving during strobe read");
  a_enable_read_drive: assert property ((sel == `LINK_SEL_ESTROBE
    && !cs_n && enable_read && write_strobe_n) [*6]
    |-> dev_oe_n == `BUS_DRIVEN)
    else $error("display not driving during enable read");
  // Enable and write strobes only begin under chip select; serial link never driven; data select steady
  a_enable_needs_cs: assert property ($rose(enable_read)
    && sel == `LINK_SEL_ESTROBE |-> !cs_n && !$past(cs_n))
    else $error("enable raised without chip select");
  a_write_needs_cs: assert property ($fell(write_strobe_n)
    && sel == `LINK_SEL_RWSTROBE |-> !cs_n && !$past(cs_n))
    else $error("write strobe without chip select");
  a_serial_no_drive: assert property (sel == `LINK_SEL_SERIAL
    |-> &dev_oe_n) else $error("display drives bus in serial link");
  a_dc_steady: assert property (!cs_n && !$past(cs_n)
    |-> $stable(data_command_select))
    else $error("data select moved inside a transfer");

  // Main scenarios reached
  c_strobe_write: cover property (sel == `LINK_SEL_RWSTROBE
    && !write_strobe_n && !cs_n);
  c_enable_read: cover property (sel == `LINK_SEL_ESTROBE
    && enable_read && write_strobe_n && !cs_n);
  c_serial_frame: cover property (sel == `LINK_SEL_SERIAL && !cs_n);
endmodule // host_link_props

// *** tb/tb.sv ***
// Self-checking bench: host end and display end joined over the pin bundle
`include "dhi_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] link_mode = `LINK_SEL_RWSTROBE;
  logic       req_valid = 1'b0;
  logic       req_read = 1'b0;
  logic       req_is_data = 1'b0;
  logic [7:0] req_data = 8'h00;
  logic [7:0] rd_data = 8'h00;
  logic       req_ready, rsp_valid, mem_we, cmd_we, read_is_data, in_reset;
  logic       mem_we_b, read_done;
  logic [7:0] rsp_data, rx_byte, rx_byte_b;
  logic [1:0] modes [2] = '{`LINK_SEL_RWSTROBE, `LINK_SEL_ESTROBE};
  int         err_count = 0;
  int         n_compared = 0;

  host_link_if u_host_link_if ();
  host_link_if u_host_link_if_b ();

  // 50 ns clock
  always #25 core_clk = ~core_clk;

  // Host end facing the display end
  host_port_end #(.TICK_CYC(2), .ACTIVE_TICKS(4)) u_host_port_end (
    .link(u_host_link_if), .CORE_CLK(core_clk), .RST_N(rst_n),
    .LINK_MODE(link_mode), .REQ_VALID(req_valid), .REQ_READ(req_read),
    .REQ_IS_DATA(req_is_data), .REQ_DATA(req_data), .REQ_READY(req_ready),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));
  display_port_end u_display_port_end (
    .link(u_host_link_if), .CORE_CLK(core_clk), .RST_N(rst_n),
    .RD_DATA(rd_data), .BYTE(rx_byte), .MEM_WE(mem_we), .CMD_WE(cmd_we),
    .READ_DONE(read_done), .READ_IS_DATA(read_is_data),
    .IN_RESET(in_reset));
  // Second display end, driven directly by the bench with stray strobe writes and an I2C write
  display_port_end u_display_port_end_b (
    .link(u_host_link_if_b), .CORE_CLK(core_clk), .RST_N(rst_n),
    .RD_DATA(8'h00), .BYTE(rx_byte_b), .MEM_WE(mem_we_b), .CMD_WE(),
    .READ_DONE(), .READ_IS_DATA(), .IN_RESET());

  host_link_props u_host_link_props (
    .CORE_CLK(core_clk), .RST_N(rst_n), .res_n(u_host_link_if.res_n),
    .link_select_0(u_host_link_if.link_select_0),
    .link_select_1(u_host_link_if.link_select_1),
    .cs_n(u_host_link_if.cs_n),
    .data_command_select(u_host_link_if.data_command_select),
    .write_strobe_n(u_host_link_if.write_strobe_n),
    .enable_read(u_host_link_if.enable_read),
    .host_oe_n(u_host_link_if.host_oe_n), .dev_oe_n(u_host_link_if.dev_oe_n));

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic timed_out();
    err_count++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    tally_and_finish();
  endtask

  // True while the parallel strobe of the active link is asserted
  function automatic logic strobing();
    if (link_mode == `LINK_SEL_RWSTROBE)
      return !u_host_link_if.write_strobe_n || !u_host_link_if.enable_read;
    return link_mode == `LINK_SEL_ESTROBE && u_host_link_if.enable_read;
  endfunction

  // Core reset with a new link choice, then wait for the host to idle
  task automatic restart(input logic [1:0] mode);
    int n;
    n = 0;
    @(posedge core_clk);
    rst_n <= 1'b0;
    link_mode <= mode;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    check(in_reset, 1'b1);
    check(u_host_link_if.dev_oe_n, `BUS_RELEASED);
    repeat (2) @(negedge core_clk);
    check(in_reset, 1'b1);
    if (mode == `LINK_SEL_I2C) begin
      repeat (80) @(negedge core_clk);
      check(req_ready, 1'b0);
    end else begin
      while (req_ready !== 1'b1) begin
        @(negedge core_clk);
        if (++n > 200) timed_out();
      end
      repeat (3) @(negedge core_clk);
      check(in_reset, 1'b0);
      check(u_host_link_if.res_n, 1'b1);
    end
  endtask

  // One byte through the host end; wire and display side judged
  task automatic xfer(input logic rd, input logic dc, input logic [7:0] d);
    logic [7:0] bus, sh;
    logic       ck;
    int         n, rises, dones;
    n = 0;
    rises = 0;
    dones = 0;
    ck = 1'b1;
    sh = 8'h00;
    bus = 8'h00;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_read <= rd;
    req_is_data <= dc;
    req_data <= d;
    rd_data <= d;
    do begin
      @(negedge core_clk);
      if (++n > 100) timed_out();
    end while (req_ready !== 1'b1);
    @(posedge core_clk);
    req_valid <= 1'b0;
    n = 0;
    forever begin
      @(negedge core_clk);
      if (++n > 150) timed_out();
      if (strobing()) bus = u_host_link_if.host_byte_bus;
      if (!u_host_link_if.cs_n && u_host_link_if.host_byte_bus[0] && !ck) begin
        sh = {sh[6:0], u_host_link_if.host_byte_bus[1]};
        rises++;
      end
      ck = u_host_link_if.host_byte_bus[0];
      if (rd && rsp_valid === 1'b1) break;
      if (!rd && (mem_we | cmd_we) === 1'b1) break;
    end
    if (rd) begin
      check(rsp_data, d);
      check(bus, d);
      check(read_is_data, dc);
      repeat (4) begin
        @(negedge core_clk);
        if (read_done === 1'b1) dones++;
      end
      check(dones[7:0], 8'h01);
    end else begin
      check(rx_byte, d);
      check(mem_we, dc);
      check(cmd_we, !dc);
      if (link_mode == `LINK_SEL_SERIAL) begin
        check(sh, d);
        check(rises[7:0], 8'h08);
      end else
        check(bus, d);
    end
  endtask

  // Strobe-style write on the second bundle, with or without chip select
  task automatic stray_write(input logic cs, input logic [7:0] d);
    int pulses;
    pulses = 0;
    @(posedge core_clk);
    u_host_link_if_b.cs_n <= cs;
    u_host_link_if_b.host_drive <= d;
    u_host_link_if_b.host_oe_n <= 8'h00;
    for (int i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (i == 4) u_host_link_if_b.write_strobe_n <= 1'b0;
      if (i == 8) u_host_link_if_b.write_strobe_n <= 1'b1;
      if (i == 12) u_host_link_if_b.cs_n <= 1'b1;
      if (i == 12) u_host_link_if_b.host_oe_n <= 8'hFF;
      @(negedge core_clk);
      if (mem_we_b === 1'b1) pulses++;
    end
    check(pulses[7:0], cs ? 8'h00 : 8'h01);
    if (!cs) check(rx_byte_b, d);
  endtask

  // I2C write on the second bundle: address, control, one data byte
  task automatic i2c_write(input logic [7:0] d);
    logic [26:0] bits;
    logic [1:0]  lv;
    int          pulses, k;
    pulses = 0;
    bits = {8'h78, 1'b1, 8'h40, 1'b1, d, 1'b1};
    @(posedge core_clk);
    u_host_link_if_b.link_select_0 <= 1'b1;
    u_host_link_if_b.link_select_1 <= 1'b0;
    u_host_link_if_b.cs_n <= 1'b0;
    u_host_link_if_b.host_drive <= 8'h00;
    for (int i = 0; i < 59; i++) begin
      k = 26 - (i - 2) / 2;
      if (i < 2)
        lv = {i == 0, 1'b1};
      else if (i < 56)
        lv = {bits[k], i[0]};
      else
        lv = {i == 58, i != 56};
      @(posedge core_clk);
      u_host_link_if_b.host_oe_n <= {6'h3F, lv};
      repeat (6) begin
        @(negedge core_clk);
        if (mem_we_b === 1'b1) pulses++;
      end
      if (i > 1 && i < 56 && i[0] && k % 9 == 0)
        check(u_host_link_if_b.host_byte_bus[1], 1'b0);
    end
    check(pulses[7:0], 8'h01);
    check(rx_byte_b, d);
  endtask

  // Main sequence
  initial begin
    u_host_link_if_b.res_n = 1'b1;
    u_host_link_if_b.link_select_0 = 1'b1;
    u_host_link_if_b.link_select_1 = 1'b1;
    u_host_link_if_b.cs_n = 1'b1;
    u_host_link_if_b.data_command_select = 1'b1;
    u_host_link_if_b.write_strobe_n = 1'b1;
    u_host_link_if_b.enable_read = 1'b1;
    u_host_link_if_b.host_drive = 8'h00;
    u_host_link_if_b.host_oe_n = 8'hFF;
    foreach (modes[i]) begin
      restart(modes[i]);
      xfer(1'b0, 1'b1, 8'hA5);
      xfer(1'b0, 1'b0, 8'h5A);
      xfer(1'b1, 1'b1, 8'hC3);
      xfer(1'b1, 1'b0, 8'h3C);
    end
    stray_write(1'b1, 8'h69);
    stray_write(1'b0, 8'hD2);
    i2c_write(8'h96);
    restart(`LINK_SEL_SERIAL);
    xfer(1'b0, 1'b1, 8'h80);
    xfer(1'b0, 1'b0, 8'h01);
    restart(`LINK_SEL_I2C);
    tally_and_finish();
  end
endmodule // tb
